// ### hw/two_wire_pkg.sv
// Purpose: shared constants and types of the two-wire bus controller
// Assumes: one 25 MHz system clock; register port indexes are word offsets
// Notes: pin idle level is high, so synchronisers reset to one on bus lines
package two_wire_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Clock and bus timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QUARTER_W = $clog2(QUARTER_CYC);
  localparam logic [QUARTER_W-1:0] QUARTER_LAST = QUARTER_W'(QUARTER_CYC - 1);
  localparam int STRETCH_NS = 20000;
  localparam int STRETCH_CYC = (STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRETCH_W = $clog2(STRETCH_CYC);
  localparam logic [STRETCH_W-1:0] STRETCH_LAST = STRETCH_W'(STRETCH_CYC - 1);
  // Register indexes
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MADDR = 4'h1;
  localparam logic [ADDR_W-1:0] REG_MCOUNT = 4'h2;
  localparam logic [ADDR_W-1:0] REG_MTX = 4'h3;
  localparam logic [ADDR_W-1:0] REG_MSTAT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h5;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h6;
  localparam logic [ADDR_W-1:0] REG_SADDR = 4'h7;
  localparam logic [ADDR_W-1:0] REG_STX = 4'h8;
  localparam logic [ADDR_W-1:0] REG_SRX = 4'h9;
  // Control bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_DIS = 1;
  localparam int CTRL_GO = 2;
  localparam int CTRL_SEN = 3;
  // Master status bits
  localparam int MST_IDLE = 0;
  localparam int MST_FULL = 1;
  localparam int MST_EN = 2;
  // Sticky event bits
  localparam int IRQ_MDONE = 0;
  localparam int IRQ_MNACK = 1;
  localparam int IRQ_ALERT = 2;
  localparam int IRQ_SDONE = 3;
  localparam int IRQ_SNACK = 4;
  localparam logic [DATA_W-1:0] IRQ_STAT_RST = 8'h04;
  localparam logic [DATA_W-1:0] MASK_RST = 8'h00;
  // Quarter-bit phases and bit counter marks
  localparam logic [1:0] PH_DRIVE = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_ACK_END = 4'h9;
  localparam logic [2:0] SYNC_RST = 3'h3;
  typedef enum logic [4:0] {
    M_IDLE = 5'b00001,
    M_START = 5'b00010,
    M_BIT = 5'b00100,
    M_WAIT = 5'b01000,
    M_STOP = 5'b10000
  } m_state_t;
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_ADDR = 6'b000010,
    S_ACK = 6'b000100,
    S_STRETCH = 6'b001000,
    S_RX = 6'b010000,
    S_TX = 6'b100000
  } s_state_t;
endpackage

// ### hw/pin_sync.sv
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: each bit is a slow level; no bus coherence between bits
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  genvar i;
  // One pair of flops per bit
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          meta[i] <= RST[i];
          q[i] <= RST[i];
        end else begin
          meta[i] <= d[i];
          q[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule // pin_sync
`default_nettype wire

// ### hw/two_wire_slave_unit.sv
// Purpose: slave side of the two-wire bus: address match, receive, transmit
// Assumes: bus lines already synchronised; flags held by the parent
// Notes: stretch after an address match lasts a fixed time
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_unit (
  input wire logic clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic [6:0] own_addr,
  input wire logic [two_wire_pkg::DATA_W-1:0] tx_data,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic nack_flag,
  output logic scl_low,
  output logic sda_low,
  output logic [two_wire_pkg::DATA_W-1:0] rx_data,
  output logic done_ev,
  output logic nack_ev
);
  import two_wire_pkg::*;
  s_state_t state;
  logic scl_q, sda_q, rw;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic [STRETCH_W-1:0] scnt;
  logic rise, fall, start, stop;
  // Bus edges seen on the synchronised lines
  assign rise = scl_s && !scl_q;
  assign fall = !scl_s && scl_q;
  assign start = scl_s && scl_q && sda_q && !sda_s;
  assign stop = scl_s && scl_q && !sda_q && sda_s;

  // Slave sequencer; start and stop win over any state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rw <= 1'b0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      scnt <= '0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      rx_data <= 8'h00;
      done_ev <= 1'b0;
      nack_ev <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      done_ev <= 1'b0;
      nack_ev <= 1'b0;
      if (!enable || stop) begin
        state <= S_IDLE;
        scl_low <= 1'b0;
        sda_low <= 1'b0;
      end else if (start) begin
        state <= S_ADDR;
        bitn <= 4'h0;
        scl_low <= 1'b0;
        sda_low <= 1'b0;
      end else begin
        unique case (state)
          S_IDLE: begin
          end
          S_ADDR: begin
            if (rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitn <= bitn + 4'h1;
            end else if (fall && bitn == BIT_ACK) begin
              if (shreg[7:1] == own_addr) begin
                state <= S_ACK;
                sda_low <= 1'b1;
                rw <= shreg[0];
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_ACK: begin
            // Hold the clock from the end of the acknowledge clock
            if (fall) begin
              state <= S_STRETCH;
              scl_low <= 1'b1;
              scnt <= '0;
              bitn <= 4'h0;
              shreg <= tx_data;
              sda_low <= rw ? !tx_data[7] : 1'b1;
            end
          end
          S_STRETCH: begin
            // In receive the data line goes with the clock, no setup gap
            if (scnt == STRETCH_LAST) begin
              scl_low <= 1'b0;
              state <= rw ? S_TX : S_RX;
              if (!rw) begin
                sda_low <= 1'b0;
              end
            end else begin
              scnt <= scnt + 1'b1;
            end
          end
          S_RX: begin
            if (rise && bitn < BIT_ACK) begin
              shreg <= {shreg[6:0], sda_s};
              bitn <= bitn + 4'h1;
            end else if (fall && bitn == BIT_ACK) begin
              sda_low <= 1'b1;
              rx_data <= shreg;
              bitn <= BIT_ACK_END;
            end else if (fall && bitn == BIT_ACK_END) begin
              sda_low <= 1'b0;
              bitn <= 4'h0;
              done_ev <= 1'b1;
            end
          end
          S_TX: begin
            if (rise && bitn == BIT_ACK) begin
              nack_ev <= sda_s;
            end else if (fall && bitn == BIT_ACK) begin
              done_ev <= 1'b1;
              // An early cleared flag keeps the slave sending
              if (nack_flag) begin
                state <= S_IDLE;
                sda_low <= 1'b0;
              end else begin
                shreg <= tx_data;
                sda_low <= !tx_data[7];
                bitn <= 4'h0;
              end
            end else if (fall && bitn == BIT_LAST) begin
              sda_low <= 1'b0;
              bitn <= BIT_ACK;
            end else if (fall) begin
              shreg <= {shreg[6:0], 1'b0};
              sda_low <= !shreg[6];
              bitn <= bitn + 4'h1;
            end
          end
        endcase
      end
    end
  end

  chk_tx_keeps_sending: assert property (@(posedge clk) disable iff (!resetn)
    enable && !stop && !start && state == S_TX && fall && bitn == BIT_ACK && !nack_flag
    |=> state == S_TX && bitn == 4'h0 && done_ev) else $error("slave did not resume");
  chk_stretch_holds_data: assert property (@(posedge clk) disable iff (!resetn)
    state == S_STRETCH && !rw |-> scl_low && sda_low) else $error("stretch lines wrong");
  chk_release_together: assert property (@(posedge clk) disable iff (!resetn)
    enable && !stop && !start && state == S_STRETCH && !rw && scnt == STRETCH_LAST
    |=> !scl_low && !sda_low && state == S_RX) else $error("release not joint");
  cov_stretch_tx: cover property (@(posedge clk) disable iff (!resetn)
    state == S_STRETCH ##1 state == S_TX);
  cov_rx_byte: cover property (@(posedge clk) disable iff (!resetn)
    state == S_RX && done_ev);
endmodule // two_wire_slave_unit
`default_nettype wire

// ### hw/two_wire_bus_master_slave.sv
// Purpose: two-wire bus controller: master engine, slave unit, register
//   port, sticky event status and one level interrupt
// Assumes: open-drain pins with pull-ups outside; 25 MHz clock
// Notes: master sends writes only; software feeds bytes one at a time
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_master_slave (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [two_wire_pkg::ADDR_W-1:0] addr,
  input wire logic [two_wire_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [two_wire_pkg::DATA_W-1:0] rdata,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic alert_in
);
  import two_wire_pkg::*;
  logic [2:0] pin_s;
  logic scl_s, sda_s, alert_s;
  logic m_en, s_en, tx_full, load_tx, idle, ack_bit;
  logic [6:0] m_addr, s_addr;
  logic [7:0] m_count, m_tx, s_tx, s_rx, wcount, shreg;
  logic [DATA_W-1:0] irq_stat, irq_mask, ev;
  logic dis_wr, go_wr, rd_stat, tick, nack_early, stop_done;
  logic m_scl_low, m_sda_low, s_scl_low, s_sda_low;
  logic m_done_ev, m_nack_ev, s_done_ev, s_nack_ev, after_rst;
  logic [QUARTER_W-1:0] qcnt;
  logic [1:0] phase;
  logic [3:0] bitn;
  m_state_t m_state;

  // Bus lines and alert cross into the clock domain
  pin_sync #(.W(3), .RST(SYNC_RST)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({alert_in, sda_in, scl_in}),
    .q(pin_s)
  );
  assign scl_s = pin_s[0];
  assign sda_s = pin_s[1];
  assign alert_s = pin_s[2];

  // Register strobes
  assign dis_wr = wr && addr == REG_CTRL && wdata[CTRL_DIS];
  assign go_wr = wr && addr == REG_CTRL && wdata[CTRL_GO];
  assign rd_stat = rd && addr == REG_IRQ_STAT;

  // Software-written configuration
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m_en <= 1'b0;
      s_en <= 1'b0;
      m_addr <= 7'h00;
      s_addr <= 7'h00;
      m_count <= 8'h00;
      m_tx <= 8'h00;
      s_tx <= 8'h00;
      irq_mask <= MASK_RST;
    end else if (wr) begin
      unique case (addr)
        REG_CTRL: begin
          if (wdata[CTRL_DIS]) begin
            m_en <= 1'b0;
          end else if (wdata[CTRL_EN]) begin
            m_en <= 1'b1;
          end
          s_en <= wdata[CTRL_SEN];
        end
        REG_MADDR: m_addr <= wdata[6:0];
        REG_MCOUNT: m_count <= wdata;
        REG_MTX: m_tx <= wdata;
        REG_IRQ_MASK: irq_mask <= wdata;
        REG_SADDR: s_addr <= wdata[6:0];
        REG_STX: s_tx <= wdata;
        default: begin
        end
      endcase
    end
  end

  // Transmit holding flag; a fresh write wins over the load
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_full <= 1'b0;
    end else if (wr && addr == REG_MTX) begin
      tx_full <= 1'b1;
    end else if (load_tx) begin
      tx_full <= 1'b0;
    end
  end

  // Quarter-bit enable pulse for the master engine
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      qcnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= qcnt == QUARTER_LAST;
      qcnt <= (qcnt == QUARTER_LAST) ? '0 : qcnt + 1'b1;
    end
  end

  // Early idle on a NACK with bytes still to send; a normal idle at the end of STOP
  assign nack_early = m_state == M_BIT && tick && phase == PH_FALL && bitn == BIT_ACK
    && ack_bit && wcount != 8'h00 && !dis_wr;
  assign stop_done = m_state == M_STOP && tick && phase == PH_FALL && !dis_wr;

  // Master engine; in M_BIT the clock line is waited for while a slave stretches, not in M_STOP
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m_state <= M_IDLE;
      phase <= PH_DRIVE;
      bitn <= 4'h0;
      shreg <= 8'h00;
      wcount <= 8'h00;
      ack_bit <= 1'b0;
      m_scl_low <= 1'b0;
      m_sda_low <= 1'b0;
      idle <= 1'b1;
      m_done_ev <= 1'b0;
      m_nack_ev <= 1'b0;
      load_tx <= 1'b0;
    end else begin
      m_done_ev <= 1'b0;
      m_nack_ev <= 1'b0;
      load_tx <= 1'b0;
      if (dis_wr) begin
        // Lines let go at once, even mid STOP
        m_state <= M_IDLE;
        m_scl_low <= 1'b0;
        m_sda_low <= 1'b0;
        idle <= 1'b1;
      end else begin
        unique case (m_state)
          M_IDLE: begin
            if (go_wr && m_en) begin
              m_state <= M_START;
              phase <= PH_DRIVE;
              idle <= 1'b0;
              wcount <= m_count;
              shreg <= {m_addr, 1'b0};
              bitn <= 4'h0;
            end
          end
          M_START: begin
            if (tick) begin
              phase <= phase + 2'h1;
              if (phase == PH_DRIVE) begin
                m_sda_low <= 1'b1;
              end else if (phase == PH_RISE) begin
                m_scl_low <= 1'b1;
                m_state <= M_BIT;
                phase <= PH_DRIVE;
              end
            end
          end
          M_BIT: begin
            if (tick && !(phase == PH_HIGH && !scl_s)) begin
              phase <= phase + 2'h1;
              unique case (phase)
                PH_DRIVE: m_sda_low <= bitn != BIT_ACK && !shreg[7];
                PH_RISE: m_scl_low <= 1'b0;
                PH_HIGH: begin
                  if (bitn == BIT_ACK) begin
                    ack_bit <= sda_s;
                  end
                end
                PH_FALL: begin
                  m_scl_low <= 1'b1;
                  if (bitn != BIT_ACK) begin
                    bitn <= bitn + 4'h1;
                    shreg <= {shreg[6:0], 1'b0};
                  end else begin
                    bitn <= 4'h0;
                    m_done_ev <= 1'b1;
                    if (ack_bit) begin
                      m_nack_ev <= 1'b1;
                      m_state <= M_STOP;
                      if (nack_early) begin
                        idle <= 1'b1;
                      end
                    end else if (wcount == 8'h00) begin
                      m_state <= M_STOP;
                    end else if (tx_full) begin
                      shreg <= m_tx;
                      wcount <= wcount - 8'h01;
                      load_tx <= 1'b1;
                    end else begin
                      m_state <= M_WAIT;
                    end
                  end
                end
              endcase
            end
          end
          M_WAIT: begin
            // Clock held low until software supplies the next byte
            if (tx_full) begin
              shreg <= m_tx;
              wcount <= wcount - 8'h01;
              load_tx <= 1'b1;
              m_state <= M_BIT;
              phase <= PH_DRIVE;
            end
          end
          M_STOP: begin
            if (tick) begin
              phase <= phase + 2'h1;
              unique case (phase)
                PH_DRIVE: m_sda_low <= 1'b1;
                PH_RISE: m_scl_low <= 1'b0;
                PH_HIGH: m_sda_low <= 1'b0;
                PH_FALL: begin
                  m_state <= M_IDLE;
                  idle <= 1'b1;
                end
              endcase
            end
          end
        endcase
      end
    end
  end

  // Slave side shares the same synchronised lines
  two_wire_slave_unit u_slave (
    .clk(clk),
    .resetn(resetn),
    .enable(s_en),
    .own_addr(s_addr),
    .tx_data(s_tx),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .nack_flag(irq_stat[IRQ_SNACK]),
    .scl_low(s_scl_low),
    .sda_low(s_sda_low),
    .rx_data(s_rx),
    .done_ev(s_done_ev),
    .nack_ev(s_nack_ev)
  );

  // Event vector; alert is active high
  always_comb begin
    ev = '0;
    ev[IRQ_MDONE] = m_done_ev;
    ev[IRQ_MNACK] = m_nack_ev;
    ev[IRQ_ALERT] = alert_s;
    ev[IRQ_SDONE] = s_done_ev;
    ev[IRQ_SNACK] = s_nack_ev;
  end

  // Sticky flags; read clears, a same-cycle event survives
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= IRQ_STAT_RST;
    end else begin
      irq_stat <= (rd_stat ? '0 : irq_stat) | ev;
    end
  end

  // Interrupt line and open-drain pin drive
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      after_rst <= 1'b1;
    end else begin
      irq <= |(irq_stat & irq_mask);
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_n <= !(m_scl_low || s_scl_low);
      sda_oe_n <= !(m_sda_low || s_sda_low);
      after_rst <= 1'b0;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (rd) begin
      unique case (addr)
        REG_CTRL: rdata <= DATA_W'({s_en, 2'h0, m_en}) << CTRL_EN;
        REG_MADDR: rdata <= {1'b0, m_addr};
        REG_MCOUNT: rdata <= m_count;
        REG_MTX: rdata <= m_tx;
        REG_MSTAT: rdata <= DATA_W'({m_en, tx_full, idle}) << MST_IDLE;
        REG_IRQ_STAT: rdata <= irq_stat;
        REG_IRQ_MASK: rdata <= irq_mask;
        REG_SADDR: rdata <= {1'b0, s_addr};
        REG_STX: rdata <= s_tx;
        REG_SRX: rdata <= s_rx;
        default: rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  chk_nack_early_idle: assert property (@(posedge clk) disable iff (!resetn)
    nack_early |=> idle && m_state == M_STOP) else $error("idle not early");
  chk_disable_release: assert property (@(posedge clk) disable iff (!resetn)
    dis_wr |=> !m_scl_low && !m_sda_low && m_state == M_IDLE && !m_en)
    else $error("disable kept lines");
  chk_alert_high: assert property (@(posedge clk) disable iff (!resetn)
    alert_s |=> irq_stat[IRQ_ALERT]) else $error("alert high missed");
  chk_alert_reset: assert property (@(posedge clk) disable iff (!resetn)
    after_rst |-> irq_stat[IRQ_ALERT]) else $error("alert flag clear at reset");
  chk_idle_after_stop: assert property (@(posedge clk) disable iff (!resetn)
    $rose(idle) |-> $past(nack_early) || $past(stop_done) || $past(dis_wr))
    else $error("idle rose early");
  cov_nack_early: cover property (@(posedge clk) disable iff (!resetn) nack_early);
  cov_full_stop: cover property (@(posedge clk) disable iff (!resetn) stop_done);
  cov_disable: cover property (@(posedge clk) disable iff (!resetn) dis_wr && !idle);
endmodule // two_wire_bus_master_slave
`default_nettype wire

// ### bench/bus_target_model.sv
// Purpose: target device on the far side of the master's bus
// Assumes: bench resolves open-drain lines with pull-ups
// Notes: acks each byte except the one numbered nak_at (address is 0)
`timescale 1ns/1ps
`default_nettype none
module bus_target_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic [1:0] nak_at,
  output logic sda_oe_n
);
  int bit_n = 0;
  int byte_n = 0;
  initial sda_oe_n = 1'b1;
  // Start seen: the start's own clock fall opens bit zero
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bit_n = -1;
      byte_n = 0;
    end
  end
  // Ack spans the ninth clock; a refused byte leaves the line to the pull-up
  always @(negedge scl) begin
    bit_n = bit_n + 1;
    if (bit_n == 8) begin
      sda_oe_n = (byte_n == int'(nak_at));
    end else if (bit_n == 9) begin
      sda_oe_n = 1'b1;
      bit_n = 0;
      byte_n = byte_n + 1;
    end
  end
endmodule // bus_target_model
`default_nettype wire

// ### bench/two_wire_bus_master_slave_tb.sv
// Purpose: self-checking bench of the two-wire controller's master side and slave unit
// Assumes: pull-ups on both lines; slave unit enabled only in its own scenario
// Notes: polling of the idle flag stands in for the interrupt path
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_master_slave_tb;
  import two_wire_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] v;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic alert_in = 1'b0;
  logic irq, scl_oe_n, sda_oe_n, t_oe_n;
  logic [1:0] nak_at = 2'h3;
  wire logic scl_w = scl_oe_n;
  wire logic sda_w = sda_oe_n & t_oe_n;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  two_wire_bus_master_slave dut_u (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .scl_in(scl_w), .scl_out(),
    .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(), .sda_oe_n(sda_oe_n), .alert_in(alert_in));
  bus_target_model tgt_u (.scl(scl_w), .sda(sda_w), .nak_at(nak_at), .sda_oe_n(t_oe_n));
  // 25 MHz system clock
  always #20 clk = ~clk;
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the longest transfer sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rreg(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic t_reset();
    rreg(REG_IRQ_STAT, v);
    chk("stat after reset", v, IRQ_STAT_RST);
    rreg(REG_IRQ_STAT, v);
    chk("stat cleared", v, 8'h00);
    rreg(4'hf, v);
    chk("unmapped", v, 8'h00);
    chk("irq idle", {7'h0, irq}, 8'h00);
  endtask
  // Alert with the slave unit off as after reset; alert_in is not on the shared pins
  task automatic t_alert();
    wreg(REG_IRQ_MASK, 8'h04);
    @(posedge clk);
    alert_in <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk("irq on high alert", {7'h0, irq}, 8'h01);
    @(posedge clk);
    alert_in <= 1'b0;
    repeat (6) @(posedge clk);
    rreg(REG_IRQ_STAT, v);
    chk("alert flag", v, 8'h04);
    rreg(REG_IRQ_STAT, v);
    chk("low alert quiet", v, 8'h00);
    chk("irq dropped", {7'h0, irq}, 8'h00);
    wreg(REG_IRQ_MASK, 8'h00);
  endtask
  task automatic t_start(input logic [7:0] cnt, input logic [1:0] nb);
    nak_at = nb;
    wreg(REG_CTRL, 8'h01);
    wreg(REG_MADDR, 8'h2a);
    wreg(REG_MCOUNT, cnt);
    wreg(REG_MTX, 8'ha5);
    wreg(REG_CTRL, 8'h04);
  endtask
  task automatic t_wait();
    v = 8'h00;
    for (int i = 0; i < 6000 && v[MST_IDLE] !== 1'b1; i++) rreg(REG_MSTAT, v);
  endtask
  // Acked transfer: idle only once the stop has left both lines high
  task automatic t_ack();
    t_start(8'h01, 2'h3);
    t_wait();
    chk("lines at idle", {6'h0, scl_w, sda_w}, 8'h03);
    rreg(REG_IRQ_STAT, v);
    chk("no nack", {7'h0, v[IRQ_MNACK]}, 8'h00);
  endtask
  // Refused data byte with one left: idle while the clock is still held low
  task automatic t_nak();
    t_start(8'h02, 2'h1);
    t_wait();
    chk("clock low at idle", {7'h0, scl_w}, 8'h00);
    rreg(REG_IRQ_STAT, v);
    chk("nack flag", {7'h0, v[IRQ_MNACK]}, 8'h01);
    // Two bus clocks after idle before any disable, so the stop gets out
    repeat (8 * QUARTER_CYC) @(posedge clk);
    #1 chk("stop out before disable", {6'h0, scl_w, sda_w}, 8'h03);
    wreg(REG_CTRL, 8'h02);
  endtask
  // Own address on the shared pins: stretch holds data low, then a byte comes in
  task automatic t_slave();
    int run;
    int best;
    run = 0;
    best = 0;
    wreg(REG_SADDR, 8'h2a);
    wreg(REG_CTRL, 8'h09);
    wreg(REG_MADDR, 8'h2a);
    wreg(REG_MCOUNT, 8'h01);
    wreg(REG_MTX, 8'ha5);
    wreg(REG_CTRL, 8'h0c);
    // Longest run with both lines low marks the address-match stretch
    repeat (6000) begin
      @(posedge clk);
      #1 run = (scl_w === 1'b0 && sda_w === 1'b0) ? run + 1 : 0;
      if (run > best) best = run;
    end
    chk("stretch data low", {7'h0, best >= 450 && best < 600}, 8'h01);
    t_wait();
    rreg(REG_SRX, v);
    chk("slave rx byte", v, 8'ha5);
    rreg(REG_IRQ_STAT, v);
    chk("slave done before clear", {7'h0, v[IRQ_SDONE]}, 8'h01);
    wreg(REG_CTRL, 8'h01);
  endtask
  // Disable in mid-address: both lines let go at once
  task automatic t_dis();
    t_start(8'h01, 2'h3);
    repeat (300) @(posedge clk);
    wreg(REG_CTRL, 8'h02);
    repeat (3) @(posedge clk);
    #1 chk("released", {6'h0, scl_oe_n, sda_oe_n}, 8'h03);
    rreg(REG_MSTAT, v);
    chk("master off", {7'h0, v[MST_EN]}, 8'h00);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_alert();
    t_ack();
    t_nak();
    t_slave();
    t_dis();
    final_report();
  end
endmodule // two_wire_bus_master_slave_tb
`default_nettype wire
